// ---- logic/rsmc_top.sv ----
// Notes on behaviour
// R1 - Enable low powers down, high runs
// R2 - Enable falling edge resets internal state
// R3 - Detect enable low: detector off, termination on
// R4 - Detect enable high: standby without input clock
// R5 - De-emphasis strap: low -2, float 0, high reserved
// R6 - Bus mode takes de-emphasis from bus
// R7 - Floating equalizer strap selects adaptive equalization
// R8 - Fixed gain: low 7.5 dB, high 14 dB
// R9 - Bus mode reads equalizer strap as address bit
// R10 - Mode select high bus, low strap
// R11 - Control bus pins used only in bus mode
// R12 - Strap mode: bus writes cannot override straps
// R13 - Latch straps and mode at reset release
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module rsmc_top (
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Device control pins
  input  wire logic                        op_enable,
  input  wire logic                        sig_detect_en,
  input  wire logic                        ctrl_mode_sel,
  input  wire logic [1:0]                  deemph_strap,
  input  wire logic [1:0]                  equalizer_strap_addr_bit,
  input  wire logic                        input_clock_valid,
  // Control bus pins, open drain
  input  wire logic                        control_bus_clock_pin_in,
  output logic                             control_bus_clock_pin_out,
  output logic                             control_bus_clock_pin_oe,
  input  wire logic                        control_bus_data_pin_in,
  output logic                             control_bus_data_pin_out,
  output logic                             control_bus_data_pin_oe,
  // Settings towards the analog path
  output logic                             power_down,
  output logic                             internal_reset,
  output logic                             sig_detect_on,
  output logic                             term_connected,
  output logic                             standby,
  output logic                             bus_mode,
  output logic [1:0]                       deemph_sel,
  output logic                             eq_adaptive,
  output logic                             eq_gain_high,
  output logic                             slave_addr_bit,
  // AXI4-Lite slave
  input  wire logic [rsmc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [rsmc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);

  // Bytes of a write word that feed the control register
  localparam int CTRL_BYTES = 1;

  rsmc_pkg::rsmc_state_t state;
  rsmc_pkg::rsmc_state_t next_state;

  logic                            op_enable_q;
  logic                            lat_bus_mode;
  logic [1:0]                      lat_deemph;
  logic                            lat_eq_adaptive;
  logic                            lat_eq_high;
  logic                            lat_addr_bit;
  logic [rsmc_pkg::CTRL_WIDTH-1:0] ctrl;

  logic                            aw_got;
  logic                            w_got;
  logic [rsmc_pkg::ADDR_W-1:0]     aw_addr_q;
  logic [31:0]                     w_data_q;
  logic [3:0]                      w_strb_q;

  wire                             en_fall;
  wire                             capture;
  wire                             aw_take;
  wire                             w_take;
  wire                             wr_fire;
  wire                             b_done;
  wire                             ar_take;
  wire                             r_done;
  wire                             next_aw_got;
  wire                             next_w_got;
  wire                             next_bvalid;
  wire                             wr_ctrl_hit;
  wire                             wr_mapped;
  wire                             rd_ctrl_hit;
  wire                             rd_stat_hit;
  wire                             ctrl_write;
  wire [1:0]                       ctrl_deemph;
  wire [1:0]                       next_deemph;
  wire                             next_eq_adaptive;
  wire                             next_eq_high;
  wire                             next_standby;
  wire                             next_term;
  wire                             next_sda_oe;
  wire                             next_scl_oe;
  wire [31:0]                      status_word;
  wire [31:0]                      ctrl_word;
  wire [31:0]                      next_rdata;
  wire [CTRL_BYTES*8-1:0]          merged_ctrl;

  // Strap decoding through the shared carrier
  rsmc_strap_if st ();

  assign st.deemph_raw = deemph_strap;
  assign st.eq_raw     = equalizer_strap_addr_bit;
  // R10 mode select high is bus mode
  assign st.bus_mode   = ctrl_mode_sel;

  rsmc_strap_decode u_decode (
    .st (st.decoder)
  );

  // Enable edge and capture conditions
  // R2 falling edge of the enable
  assign en_fall = op_enable_q & ~op_enable;
  assign capture = (state == rsmc_pkg::RSMC_ST_CAPTURE);

  // Control flow: capture straps, run, power down
  always_comb begin
    next_state = state;
    case (state)
      rsmc_pkg::RSMC_ST_CAPTURE: begin
        next_state = op_enable ? rsmc_pkg::RSMC_ST_RUN : rsmc_pkg::RSMC_ST_POWER_DOWN;
      end
      rsmc_pkg::RSMC_ST_RUN: begin
        // R1 low enable powers down
        if (!op_enable) begin
          next_state = rsmc_pkg::RSMC_ST_POWER_DOWN;
        end
      end
      rsmc_pkg::RSMC_ST_POWER_DOWN: begin
        // R2 restart recaptures straps
        if (op_enable) begin
          next_state = rsmc_pkg::RSMC_ST_CAPTURE;
        end
      end
      default: begin
        next_state = rsmc_pkg::RSMC_ST_CAPTURE;
      end
    endcase
  end

  // State register and enable history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= rsmc_pkg::RSMC_ST_CAPTURE;
      op_enable_q <= 1'b1;
    end else begin
      state       <= next_state;
      op_enable_q <= op_enable;
    end
  end

  // R13 latch decoded straps in the capture state, after reset and on each re-enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_bus_mode    <= 1'b0;
      lat_deemph      <= rsmc_pkg::DEEMPH_0DB;
      lat_eq_adaptive <= 1'b1;
      lat_eq_high     <= 1'b0;
      lat_addr_bit    <= 1'b0;
    end else if (capture) begin
      lat_bus_mode    <= st.bus_mode;
      lat_deemph      <= st.deemph_code;
      lat_eq_adaptive <= st.eq_adaptive;
      lat_eq_high     <= st.eq_gain_high;
      lat_addr_bit    <= st.addr_bit;
    end
  end

  // Effective settings: bus values only in bus mode
  assign ctrl_deemph = ctrl[rsmc_pkg::CTRL_DEEMPH_LSB +: 2];
  // R6 bus drives de-emphasis in bus mode
  assign next_deemph = lat_bus_mode ? ctrl_deemph : lat_deemph;
  // R12 straps win in strap mode
  assign next_eq_adaptive = lat_bus_mode ? ctrl[rsmc_pkg::CTRL_EQ_ADAPT_BIT] : lat_eq_adaptive;
  assign next_eq_high     = lat_bus_mode ? ctrl[rsmc_pkg::CTRL_EQ_HIGH_BIT] : lat_eq_high;

  // Signal detect and termination
  // R4 standby without a valid clock
  assign next_standby = sig_detect_en & ~input_clock_valid & op_enable;
  // R3 termination held while detector off
  assign next_term    = ~sig_detect_en | input_clock_valid;

  // R11 pins only driven in bus mode
  assign next_sda_oe = lat_bus_mode & ctrl[rsmc_pkg::CTRL_SDA_LOW_BIT];
  assign next_scl_oe = lat_bus_mode & ctrl[rsmc_pkg::CTRL_SCL_LOW_BIT];

  // Device facing outputs, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_down     <= 1'b1;
      internal_reset <= 1'b0;
      sig_detect_on  <= 1'b0;
      term_connected <= 1'b1;
      standby        <= 1'b0;
      bus_mode       <= 1'b0;
      deemph_sel     <= rsmc_pkg::DEEMPH_0DB;
      eq_adaptive    <= 1'b1;
      eq_gain_high   <= 1'b0;
      slave_addr_bit <= 1'b0;
    end else begin
      // R1 power down follows the enable
      power_down     <= ~op_enable;
      // R2 one-cycle internal reset
      internal_reset <= en_fall;
      // R3 detector off when disabled
      sig_detect_on  <= sig_detect_en;
      term_connected <= next_term;
      standby        <= next_standby;
      bus_mode       <= lat_bus_mode;
      deemph_sel     <= next_deemph;
      eq_adaptive    <= next_eq_adaptive;
      eq_gain_high   <= next_eq_high;
      // R9 address bit in bus mode
      slave_addr_bit <= lat_addr_bit;
    end
  end

  // Open-drain control bus pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_bus_clock_pin_out <= 1'b0;
      control_bus_clock_pin_oe  <= 1'b0;
      control_bus_data_pin_out  <= 1'b0;
      control_bus_data_pin_oe   <= 1'b0;
    end else begin
      control_bus_clock_pin_out <= 1'b0;
      control_bus_clock_pin_oe  <= next_scl_oe;
      control_bus_data_pin_out  <= 1'b0;
      control_bus_data_pin_oe   <= next_sda_oe;
    end
  end

  // Write channel handshakes
  assign aw_take     = s_axi_awvalid & s_axi_awready;
  assign w_take      = s_axi_wvalid & s_axi_wready;
  assign next_aw_got = aw_got | aw_take;
  assign next_w_got  = w_got | w_take;
  assign wr_fire     = aw_got & w_got & ~s_axi_bvalid;
  assign b_done      = s_axi_bvalid & s_axi_bready;
  assign next_bvalid = wr_fire | (s_axi_bvalid & ~s_axi_bready);

  // Write decode
  assign wr_ctrl_hit = (aw_addr_q == rsmc_pkg::CTRL_OFFSET);
  assign wr_mapped   = wr_ctrl_hit | (aw_addr_q == rsmc_pkg::STATUS_OFFSET);
  // R12 control writes ignored in strap mode
  assign ctrl_write  = wr_fire & wr_ctrl_hit & lat_bus_mode & w_strb_q[0];
  assign merged_ctrl = w_data_q[CTRL_BYTES*8-1:0];

  // Address and data holding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_got <= wr_fire ? 1'b0 : next_aw_got;
      w_got  <= wr_fire ? 1'b0 : next_w_got;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Write ready and response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= rsmc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~(next_aw_got & ~wr_fire) & ~next_bvalid;
      s_axi_wready  <= ~(next_w_got & ~wr_fire) & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (wr_fire) begin
        s_axi_bresp <= wr_mapped ? rsmc_pkg::RESP_OKAY : rsmc_pkg::RESP_SLVERR;
      end
    end
  end

  // Control register, set to CTRL_RESET by the enable falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= rsmc_pkg::CTRL_RESET;
    end else if (en_fall) begin
      // R2 internal state back to reset
      ctrl <= rsmc_pkg::CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl <= merged_ctrl[rsmc_pkg::CTRL_WIDTH-1:0];
    end
  end

  // Read decode and status assembly
  assign rd_ctrl_hit = (s_axi_araddr == rsmc_pkg::CTRL_OFFSET);
  assign rd_stat_hit = (s_axi_araddr == rsmc_pkg::STATUS_OFFSET);
  assign ctrl_word   = {{(32-rsmc_pkg::CTRL_WIDTH){1'b0}}, ctrl};
  assign status_word = {20'h0_0000,
                        control_bus_data_pin_in & lat_bus_mode,
                        control_bus_clock_pin_in & lat_bus_mode,
                        slave_addr_bit,
                        deemph_sel,
                        eq_gain_high,
                        eq_adaptive,
                        term_connected,
                        standby,
                        sig_detect_on,
                        bus_mode,
                        power_down};
  assign next_rdata  = rd_ctrl_hit ? ctrl_word :
                       rd_stat_hit ? status_word : 32'h0000_0000;
  assign ar_take     = s_axi_arvalid & s_axi_arready;
  assign r_done      = s_axi_rvalid & s_axi_rready;

  // Read channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= rsmc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~ar_take & ~(s_axi_rvalid & ~r_done);
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= (rd_ctrl_hit | rd_stat_hit) ? rsmc_pkg::RESP_OKAY
                                                    : rsmc_pkg::RESP_SLVERR;
      end else if (r_done) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // rsmc_top

// ---- logic/rsmc_pkg.sv ----
package rsmc_pkg;

  // Three-level strap pin codes as presented on the raw strap inputs
  localparam logic [1:0] LVL_CODE_LOW   = 2'h0;
  localparam logic [1:0] LVL_CODE_FLOAT = 2'h1;
  localparam logic [1:0] LVL_CODE_HIGH  = 2'h2;

  typedef enum logic [1:0] {
    RSMC_LVL_LOW,
    RSMC_LVL_FLOAT,
    RSMC_LVL_HIGH
  } rsmc_level_t;

  // De-emphasis setting codes
  localparam logic [1:0] DEEMPH_M2DB = 2'h0;
  localparam logic [1:0] DEEMPH_0DB  = 2'h1;
  localparam logic [1:0] DEEMPH_RSVD = 2'h2;

  // Control flow states of the loader
  typedef enum logic [1:0] {
    RSMC_ST_CAPTURE,
    RSMC_ST_RUN,
    RSMC_ST_POWER_DOWN
  } rsmc_state_t;

  // Register map, byte addresses
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;

  // Control register fields
  localparam int          CTRL_WIDTH        = 6;
  localparam int          CTRL_DEEMPH_LSB   = 0;
  localparam int          CTRL_EQ_ADAPT_BIT = 2;
  localparam int          CTRL_EQ_HIGH_BIT  = 3;
  localparam int          CTRL_SDA_LOW_BIT  = 4;
  localparam int          CTRL_SCL_LOW_BIT  = 5;
  localparam logic [5:0]  CTRL_RESET        = 6'h05;

  // Status register fields
  localparam int STAT_POWER_DOWN = 0;
  localparam int STAT_BUS_MODE   = 1;
  localparam int STAT_SIGDET_ON  = 2;
  localparam int STAT_STANDBY    = 3;
  localparam int STAT_TERM       = 4;
  localparam int STAT_EQ_ADAPT   = 5;
  localparam int STAT_EQ_HIGH    = 6;
  localparam int STAT_DEEMPH_LSB = 7;
  localparam int STAT_ADDR_BIT   = 9;
  localparam int STAT_SCL_IN     = 10;
  localparam int STAT_SDA_IN     = 11;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Raw strap code to level; the unused code reads as floating
  function automatic rsmc_level_t lvl_decode(input logic [1:0] code);
    case (code)
      LVL_CODE_LOW:  lvl_decode = RSMC_LVL_LOW;
      LVL_CODE_HIGH: lvl_decode = RSMC_LVL_HIGH;
      default:       lvl_decode = RSMC_LVL_FLOAT;
    endcase
  endfunction

endpackage

// ---- logic/rsmc_strap_if.sv ----
`timescale 1ns/1ps
interface rsmc_strap_if;
  logic [1:0] deemph_raw;
  logic [1:0] eq_raw;
  logic       bus_mode;
  logic [1:0] deemph_code;
  logic       eq_adaptive;
  logic       eq_gain_high;
  logic       addr_bit;

  modport decoder (
    input  deemph_raw,
    input  eq_raw,
    input  bus_mode,
    output deemph_code,
    output eq_adaptive,
    output eq_gain_high,
    output addr_bit
  );

  modport user (
    output deemph_raw,
    output eq_raw,
    output bus_mode,
    input  deemph_code,
    input  eq_adaptive,
    input  eq_gain_high,
    input  addr_bit
  );
endinterface

// ---- logic/rsmc_strap_decode.sv ----
`timescale 1ns/1ps
module rsmc_strap_decode (
  rsmc_strap_if.decoder st
);

  wire rsmc_pkg::rsmc_level_t deemph_lvl;
  wire rsmc_pkg::rsmc_level_t eq_lvl;

  assign deemph_lvl = rsmc_pkg::lvl_decode(st.deemph_raw);
  assign eq_lvl     = rsmc_pkg::lvl_decode(st.eq_raw);

  // R5 three-level de-emphasis
  assign st.deemph_code = (deemph_lvl == rsmc_pkg::RSMC_LVL_LOW)   ? rsmc_pkg::DEEMPH_M2DB :
                          (deemph_lvl == rsmc_pkg::RSMC_LVL_FLOAT) ? rsmc_pkg::DEEMPH_0DB :
                                                                    rsmc_pkg::DEEMPH_RSVD;

  // R7 floating means adaptive
  assign st.eq_adaptive  = (eq_lvl == rsmc_pkg::RSMC_LVL_FLOAT);
  // R8 low 7.5 dB, high 14 dB
  assign st.eq_gain_high = (eq_lvl == rsmc_pkg::RSMC_LVL_HIGH);

  // R9 two-level address bit in bus mode
  assign st.addr_bit = st.bus_mode & (st.eq_raw == rsmc_pkg::LVL_CODE_HIGH);

endmodule // rsmc_strap_decode

// ---- verification/rsmc_board.sv ----
`timescale 1ns/1ps
module rsmc_board (
  input  wire logic [1:0] deemph_cfg,
  input  wire logic [1:0] eq_cfg,
  input  wire logic       control_bus_clock_pin_out,
  input  wire logic       control_bus_clock_pin_oe,
  input  wire logic       control_bus_data_pin_out,
  input  wire logic       control_bus_data_pin_oe,
  output logic      [1:0] deemph_strap,
  output logic      [1:0] equalizer_strap_addr_bit,
  output logic            control_bus_clock_pin_in,
  output logic            control_bus_data_pin_in
);
  // Strap resistors present the chosen levels
  assign deemph_strap             = deemph_cfg;
  assign equalizer_strap_addr_bit = eq_cfg;
  // idle host lines
  // Host never drives; pull-ups win unless the device pulls low
  assign control_bus_clock_pin_in = control_bus_clock_pin_oe ? control_bus_clock_pin_out : 1'h1;
  assign control_bus_data_pin_in  = control_bus_data_pin_oe ? control_bus_data_pin_out : 1'h1;
endmodule // rsmc_board

// ---- verification/rsmc_properties.sv ----
`timescale 1ns/1ps
module rsmc_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       op_enable,
  input wire logic       sig_detect_en,
  input wire logic       input_clock_valid,
  input wire logic       power_down,
  input wire logic       internal_reset,
  input wire logic       sig_detect_on,
  input wire logic       term_connected,
  input wire logic       standby,
  input wire logic       bus_mode,
  input wire logic [1:0] deemph_sel,
  input wire logic       slave_addr_bit,
  input wire logic       control_bus_clock_pin_oe,
  input wire logic       control_bus_data_pin_oe,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  logic run_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Marks edges whose previous sample lies outside reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 1'h0;
    end else begin
      run_q <= 1'h1;
    end
  end

  sequence s_enable_fall;
    run_q && $fell(op_enable);
  endsequence

  sequence s_reset_pulse;
    internal_reset ##1 !internal_reset;
  endsequence

  AST_POWER_DOWN: assert property (run_q |-> power_down == !$past(op_enable))
    else $error("power_down does not follow enable");
  AST_RESET_PULSE: assert property (s_enable_fall |=> s_reset_pulse)
    else $error("no single reset pulse after enable fall");
  AST_DETECT_OFF: assert property (run_q && !$past(sig_detect_en) |->
    !sig_detect_on && term_connected && !standby)
    else $error("detector active while disabled");
  AST_STANDBY: assert property (run_q |-> standby == ($past(sig_detect_en) &&
    !$past(input_clock_valid) && $past(op_enable)))
    else $error("standby wrong");
  AST_TERM: assert property (run_q && $past(sig_detect_en) |->
    sig_detect_on && term_connected == $past(input_clock_valid))
    else $error("termination wrong with detector on");
  AST_MODE_HOLD: assert property ((run_q && op_enable) [*6] |->
    $stable(bus_mode) && $stable(slave_addr_bit))
    else $error("latched mode changed");
  AST_STRAP_WRITE: assert property (!bus_mode && s_axi_bvalid |=> $stable(deemph_sel) [*2])
    else $error("bus write changed strap setting");
  AST_PIN_IDLE: assert property (run_q && !bus_mode |->
    !control_bus_clock_pin_oe && !control_bus_data_pin_oe)
    else $error("control pins driven in strap mode");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
endmodule // rsmc_props

bind rsmc_top rsmc_props props_u (.*);

// ---- verification/retimer_strap_mode_control_test.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module retimer_strap_mode_control_test;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        op_enable = 1'h1;
  logic        sig_detect_en = 1'h0;
  logic        ctrl_mode_sel = 1'h0;
  logic        input_clock_valid = 1'h1;
  logic [1:0]  deemph_cfg = 2'h1;
  logic [1:0]  eq_cfg = 2'h1;
  logic [1:0]  deemph_strap, equalizer_strap_addr_bit, deemph_sel;
  logic        control_bus_clock_pin_in, control_bus_clock_pin_out, control_bus_clock_pin_oe;
  logic        control_bus_data_pin_in, control_bus_data_pin_out, control_bus_data_pin_oe;
  logic        power_down, internal_reset, sig_detect_on, term_connected, standby;
  logic        bus_mode, eq_adaptive, eq_gain_high, slave_addr_bit;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1;
  logic        s_axi_rready = 1'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          tests_run = 0;
  int          miscompares = 0;

  rsmc_top dut_u (.*);
  rsmc_board board_u (.*);

  // Free-running system clock
  always #20 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset(input logic m, input logic [1:0] d, input logic [1:0] e);
    ctrl_mode_sel <= m;
    deemph_cfg <= d;
    eq_cfg <= e;
    rst <= 1'h1;
    cyc(4);
    rst <= 1'h0;
    cyc(3);
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    if (n >= 50) miscompares++;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 50) miscompares++;
  endtask

  // Detector enable, standby and termination
  task automatic t_sigdet();
    input_clock_valid <= 1'h0;
    cyc(3);
    `CHK({sig_detect_on, term_connected, standby}, 3'h2)
    sig_detect_en <= 1'h1;
    cyc(3);
    `CHK({sig_detect_on, term_connected, standby}, 3'h5)
    input_clock_valid <= 1'h1;
    cyc(3);
    `CHK({sig_detect_on, term_connected, standby}, 3'h6)
    sig_detect_en <= 1'h0;
    cyc(2);
    $display("t_sigdet done");
  endtask

  // Every strap level, latched, immune to bus writes
  task automatic t_strap();
    logic [1:0] c [3];
    logic [1:0] x [3];
    logic [1:0] r;
    c = '{rsmc_pkg::LVL_CODE_LOW, rsmc_pkg::LVL_CODE_FLOAT, rsmc_pkg::LVL_CODE_HIGH};
    x = '{rsmc_pkg::DEEMPH_M2DB, rsmc_pkg::DEEMPH_0DB, rsmc_pkg::DEEMPH_RSVD};
    for (int i = 0; i < 3; i++) begin
      do_reset(1'h0, c[i], c[i]);
      `CHK(bus_mode, 1'h0)
      `CHK(deemph_sel, x[i])
      `CHK(eq_adaptive, 1'(i == 1))
      `CHK(eq_gain_high, 1'(i == 2))
      `CHK(slave_addr_bit, 1'h0)
      deemph_cfg <= c[(i + 1) % 3];
      axi_wr(rsmc_pkg::CTRL_OFFSET, 32'h0000003A, r);
      cyc(3);
      `CHK(r, rsmc_pkg::RESP_OKAY)
      `CHK(deemph_sel, x[i])
      `CHK({control_bus_clock_pin_oe, control_bus_data_pin_oe}, 2'h0)
    end
    $display("t_strap done");
  endtask

  // Bus mode: address bit, bus-set de-emphasis, pins, refusals
  task automatic t_bus();
    logic [31:0] d;
    logic [1:0]  r;
    do_reset(1'h1, rsmc_pkg::LVL_CODE_LOW, rsmc_pkg::LVL_CODE_HIGH);
    `CHK({bus_mode, slave_addr_bit}, 2'h3)
    axi_wr(rsmc_pkg::CTRL_OFFSET, 32'h00000032, r);
    cyc(2);
    `CHK(deemph_sel, rsmc_pkg::DEEMPH_RSVD)
    `CHK({control_bus_clock_pin_oe, control_bus_data_pin_oe}, 2'h3)
    axi_rd(rsmc_pkg::STATUS_OFFSET, d, r);
    `CHK({d[11:7], d[1]}, 6'h0D)
    axi_wr(4'h8, 32'h00000001, r);
    `CHK(r, rsmc_pkg::RESP_SLVERR)
    axi_rd(4'hC, d, r);
    `CHK({r, d}, {rsmc_pkg::RESP_SLVERR, 32'h0})
    axi_wr(rsmc_pkg::CTRL_OFFSET, 32'h00000008, r);
    cyc(2);
    `CHK({deemph_sel, eq_adaptive, eq_gain_high}, 4'h1)
    `CHK(control_bus_data_pin_in, 1'h1)
    s_axi_wstrb <= 4'h0;
    axi_wr(rsmc_pkg::CTRL_OFFSET, 32'h00000032, r);
    s_axi_wstrb <= 4'hF;
    cyc(2);
    `CHK({deemph_sel, control_bus_data_pin_oe}, 3'h0)
    $display("t_bus done");
  endtask

  // Enable low powers down; its fall resets the control state
  task automatic t_power();
    op_enable <= 1'h0;
    cyc(2);
    `CHK({power_down, internal_reset}, 2'h3)
    cyc(1);
    `CHK({power_down, internal_reset}, 2'h2)
    op_enable <= 1'h1;
    cyc(4);
    `CHK(power_down, 1'h0)
    `CHK({deemph_sel, eq_adaptive}, {rsmc_pkg::DEEMPH_0DB, 1'h1})
    $display("t_power done");
  endtask

  task automatic end_sim();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset(1'h0, 2'h1, 2'h1);
    t_sigdet();
    t_strap();
    t_bus();
    t_power();
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule // retimer_strap_mode_control_test
